// ===== core/prop_regulator.v
// Proportional regulator producing the signed amplitude correction.
`timescale 1ns/1ns
module prop_regulator (
	input wire core_clk,
	input wire rstn,
	input wire update,
	input wire freeze,
	input wire [3:0] gain,
	input wire [7:0] target,
	input wire [7:0] measured,
	output reg signed [9:0] corr_r
);
	wire signed [8:0] err;
	wire signed [13:0] step;
	wire signed [11:0] sum;
	reg signed [9:0] corr_nxt;

	assign err = $signed({1'b0, target}) - $signed({1'b0, measured});
	assign step = err * $signed({1'b0, gain});
	// Scaling by eight keeps gain 1 gentle enough for a stable loop.
	assign sum = {{2{corr_r[9]}}, corr_r} + {{1{step[13]}}, step[13:3]};

	always @* begin
		corr_nxt = corr_r;
		if (update && !freeze) begin
			if (sum > 12'sd511)
				corr_nxt = 10'sd511;
			else if (sum < -12'sd511)
				corr_nxt = -10'sd511;
			else
				corr_nxt = sum[9:0];
		end
	end

	always @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			corr_r <= 10'sd0;
		else
			corr_r <= corr_nxt;
	end
endmodule

// ===== core/pwm_amp_consts.vh
// Constants for the voltage PWM amplitude regulator.
`ifndef PWM_AMP_CONSTS_VH
`define PWM_AMP_CONSTS_VH
`define ADDR_CHOP_CFG 8'h00
`define ADDR_CUR_CFG 8'h04
`define ADDR_STATUS 8'h08
`define ADDR_TUNED 8'h0c
`define ADDR_STEP_INT 8'h10
`define CHOP_CFG_RESET 32'h00000000
`define CUR_CFG_RESET 32'h00001f00
`define CFG_OFS_LSB 0
`define CFG_GRAD_LSB 8
`define CFG_FREQ_LSB 16
`define CFG_AUTOSCALE_BIT 18
`define CFG_AUTOGRAD_BIT 19
`define CFG_BLANK_LSB 20
`define CFG_DECAY_SENSE_BIT 22
`define CFG_GAIN_LSB 24
`define CUR_HOLD_LSB 0
`define CUR_RUN_LSB 8
`define CUR_LOAD_LSB 16
`define CUR_LOAD_EN_BIT 21
`define CUR_FREEWHEEL_BIT 22
`define CUR_HOLD_ACT_BIT 23
`define PERIOD_F0 10'd512
`define PERIOD_F1 10'd342
`define PERIOD_F2 10'd256
`define PERIOD_F3 10'd205
`define BLANK_T0 6'd16
`define BLANK_T1 6'd24
`define BLANK_T2 6'd36
`define BLANK_T3 6'd54
`define AMP_MAX 10'd1023
`define AMP8_MAX 10'd255
`define SINE_PEAK 8'd248
`define STEP_INT_MAX 20'hfffff
`define GRAD_STEPS 11'd2047
`define CS_TUNE_MIN 5'd8
`endif

// ===== core/step_amp_divider.v
// Sequential divider forming gradient*256/step_interval.
`timescale 1ns/1ns
module step_amp_divider (
	input wire core_clk,
	input wire rstn,
	input wire start,
	input wire [7:0] gradient,
	input wire [19:0] step_interval,
	output reg [15:0] quot_r
);
	reg [15:0] q_r;
	reg [20:0] rem_r;
	reg [19:0] den_r;
	reg [4:0] cnt_r;
	wire [20:0] trial;

	assign trial = {rem_r[19:0], q_r[15]};

	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			q_r <= 16'h0000;
			rem_r <= 21'h000000;
			den_r <= 20'h00000;
			cnt_r <= 5'h00;
			quot_r <= 16'h0000;
		end else if (start) begin
			q_r <= {gradient, 8'h00};
			rem_r <= 21'h000000;
			den_r <= step_interval;
			cnt_r <= 5'h10;
		end else if (cnt_r != 5'h00) begin
			if (trial >= {1'b0, den_r}) begin
				rem_r <= trial - {1'b0, den_r};
				q_r <= {q_r[14:0], 1'b1};
			end else begin
				rem_r <= trial;
				q_r <= {q_r[14:0], 1'b0};
			end
			cnt_r <= cnt_r - 5'h01;
			// A zero interval gives all ones, which the caller saturates.
			if (cnt_r == 5'h01)
				quot_r <= (den_r == 20'h00000) ? 16'hffff :
					((trial >= {1'b0, den_r}) ? {q_r[14:0], 1'b1} : {q_r[14:0], 1'b0});
		end
	end
endmodule

// ===== core/voltage_pwm_amplitude_regulator.v
// Voltage PWM amplitude regulator with AHB-Lite register access.
// Function
// [R1] Both autoscale and autotune set: regulate coil current toward target current.
// [R2] Correction adjusted proportionally by programmed gain on current error.
// [R3] Regulator also absorbs velocity changes during motion tuning phase.
// [R4] Decay sensing off: sample current only in chopper on phase after blank.
// [R5] Decay sensing on: also sample current during slow decay.
// [R6] Decay sensing enable is chopper config bit 22.
// [R7] Host programs run current scale of at least 8 for tuning.
// [R8] Host keeps standstill tuning current above lower regulation limit.
// [R9] After tuning, low current scales realised from tuned offset and gradient.
// [R10] Non-automatic mode uses programmed offset and gradient for reduced currents.
// [R11] Freewheeling lets coil amplitude go fully to zero.
// [R12] Autoscale off: pure velocity scaling, no regulation loop.
// [R13] Velocity scaling uses cycles between successive microsteps.
// [R14] Total = offset*(cs+1)/32 + gradient*256/step interval.
// [R15] Current scale follows hold, run or load-adaptive reduction.
// [R16] Amplitude is 8-bit, applied to a sine table peaking at 248.
// [R17] Tuned offset and gradient readable through read-only fields.
// [R18] Total amplitude saturates at 1023.
// [R19] Correction updated at most once per chopper period from its sample.
//
// Our own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ns
`include "pwm_amp_consts.vh"
module voltage_pwm_amplitude_regulator (
	input wire core_clk,
	input wire rstn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	input wire step_pulse,
	input wire chop_on_phase,
	input wire slow_decay_phase,
	input wire [7:0] coil_current,
	output reg [9:0] total_amplitude,
	output reg [7:0] pwm_amplitude,
	output reg [7:0] sine_peak_level,
	output reg period_start
);
	reg [31:0] chop_cfg_r;
	reg [31:0] cur_cfg_r;
	reg wr_pend_r;
	reg [7:0] wr_addr_r;
	reg [9:0] period_cnt_r;
	reg [5:0] blank_cnt_r;
	reg prev_on_r;
	reg prev_decay_r;
	reg sample_ok_r;
	reg [7:0] sample_r;
	reg update_r;
	reg [19:0] step_cnt_r;
	reg [19:0] step_interval_r;
	reg [7:0] tuned_offset_r;
	reg [7:0] tuned_grad_r;
	reg ofs_done_r;
	reg grad_done_r;
	reg [10:0] grad_steps_r;
	reg [4:0] cs;
	reg [17:0] sum_s;
	reg [9:0] total_nxt;
	reg [31:0] rd_nxt;
	wire [7:0] amplitude_offset;
	wire [7:0] gradient;
	wire autoscale;
	wire autograd;
	wire auto_mode;
	wire decay_phase_sensing_en;
	wire [3:0] reg_gain;
	wire [4:0] hold_current_scale;
	wire [4:0] run_current_scale;
	wire freewheel_en;
	wire standstill;
	wire sense_window;
	wire [15:0] vel_quot;
	wire signed [9:0] corr;
	wire [7:0] ofs_use;
	wire [7:0] grad_use;
	wire [13:0] ofs_prod;
	wire [15:0] sine_prod;

	function [9:0] period_len;
		input [1:0] sel;
		begin
			if (sel == 2'd0)
				period_len = `PERIOD_F0;
			else if (sel == 2'd1)
				period_len = `PERIOD_F1;
			else if (sel == 2'd2)
				period_len = `PERIOD_F2;
			else
				period_len = `PERIOD_F3;
		end
	endfunction

	function [5:0] blank_len;
		input [1:0] sel;
		begin
			if (sel == 2'd0)
				blank_len = `BLANK_T0;
			else if (sel == 2'd1)
				blank_len = `BLANK_T1;
			else if (sel == 2'd2)
				blank_len = `BLANK_T2;
			else
				blank_len = `BLANK_T3;
		end
	endfunction

	assign amplitude_offset = chop_cfg_r[`CFG_OFS_LSB +: 8];
	assign gradient = chop_cfg_r[`CFG_GRAD_LSB +: 8];
	assign autoscale = chop_cfg_r[`CFG_AUTOSCALE_BIT];
	assign autograd = chop_cfg_r[`CFG_AUTOGRAD_BIT];
	assign decay_phase_sensing_en = chop_cfg_r[`CFG_DECAY_SENSE_BIT]; // [R6]
	assign reg_gain = chop_cfg_r[`CFG_GAIN_LSB +: 4];
	assign hold_current_scale = cur_cfg_r[`CUR_HOLD_LSB +: 5];
	assign run_current_scale = cur_cfg_r[`CUR_RUN_LSB +: 5];
	assign freewheel_en = cur_cfg_r[`CUR_FREEWHEEL_BIT];
	assign auto_mode = autoscale && autograd; // [R1] [R12]
	assign standstill = (step_cnt_r == `STEP_INT_MAX);

	// Current scale in use: load-adaptive value wins over hold and run.
	always @* begin
		if (cur_cfg_r[`CUR_LOAD_EN_BIT])
			cs = cur_cfg_r[`CUR_LOAD_LSB +: 5]; // [R15]
		else if (cur_cfg_r[`CUR_HOLD_ACT_BIT])
			cs = hold_current_scale; // [R15]
		else
			cs = run_current_scale;
	end

	// AHB-Lite slave: zero wait states, always OKAY; unmapped reads return zero.
	always @* begin
		rd_nxt = 32'h00000000;
		if (haddr[7:0] == `ADDR_CHOP_CFG)
			rd_nxt = chop_cfg_r;
		else if (haddr[7:0] == `ADDR_CUR_CFG)
			rd_nxt = cur_cfg_r;
		else if (haddr[7:0] == `ADDR_STATUS)
			rd_nxt = {8'h00, pwm_amplitude, 6'h00, total_amplitude};
		else if (haddr[7:0] == `ADDR_TUNED)
			rd_nxt = {14'h0000, grad_done_r, ofs_done_r, tuned_grad_r, tuned_offset_r}; // [R17]
		else if (haddr[7:0] == `ADDR_STEP_INT)
			rd_nxt = {12'h000, step_interval_r};
	end

	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			chop_cfg_r <= `CHOP_CFG_RESET;
			cur_cfg_r <= `CUR_CFG_RESET;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend_r <= 1'b0;
			if (hsel && htrans[1] && hready) begin
				wr_pend_r <= hwrite;
				wr_addr_r <= haddr[7:0];
				if (!hwrite)
					hrdata <= rd_nxt;
			end
			if (wr_pend_r) begin
				if (wr_addr_r == `ADDR_CHOP_CFG)
					chop_cfg_r <= hwdata & 32'h0f7fffff;
				else if (wr_addr_r == `ADDR_CUR_CFG)
					cur_cfg_r <= hwdata & 32'h00ff1f1f;
			end
		end
	end

	// Chopper period timing and current sampling window.
	assign sense_window = (chop_on_phase && blank_cnt_r == 6'd0) ||
		(decay_phase_sensing_en && slow_decay_phase); // [R4] [R5]

	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			period_cnt_r <= 10'd0;
			period_start <= 1'b0;
			blank_cnt_r <= 6'd0;
			prev_on_r <= 1'b0;
			prev_decay_r <= 1'b0;
			sample_ok_r <= 1'b0;
			sample_r <= 8'h00;
			update_r <= 1'b0;
		end else begin
			prev_on_r <= chop_on_phase;
			prev_decay_r <= slow_decay_phase;
			update_r <= 1'b0;
			period_start <= 1'b0;
			// Switching edges ring, so each phase waits out the blank time.
			if ((chop_on_phase && !prev_on_r) || (slow_decay_phase && !prev_decay_r))
				blank_cnt_r <= blank_len(chop_cfg_r[`CFG_BLANK_LSB +: 2]); // [R4]
			else if (blank_cnt_r != 6'd0)
				blank_cnt_r <= blank_cnt_r - 6'd1;
			if (period_cnt_r >= period_len(chop_cfg_r[`CFG_FREQ_LSB +: 2]) - 10'd1) begin
				period_cnt_r <= 10'd0;
				period_start <= 1'b1;
				update_r <= sample_ok_r; // [R19]
				sample_ok_r <= 1'b0;
			end else begin
				period_cnt_r <= period_cnt_r + 10'd1;
				if (sense_window && blank_cnt_r == 6'd0) begin
					sample_r <= coil_current; // [R19]
					sample_ok_r <= 1'b1;
				end
			end
		end
	end

	// Step interval measured in clock cycles between microsteps.
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			step_cnt_r <= `STEP_INT_MAX;
			step_interval_r <= `STEP_INT_MAX;
		end else if (step_pulse) begin
			step_interval_r <= step_cnt_r; // [R13]
			step_cnt_r <= 20'h00001;
		end else if (step_cnt_r != `STEP_INT_MAX) begin
			step_cnt_r <= step_cnt_r + 20'h00001;
		end else begin
			step_interval_r <= `STEP_INT_MAX;
		end
	end

	// Regulation freezes at zero target with freewheeling enabled, so restart is quick.
	prop_regulator u_reg (
		.core_clk(core_clk),
		.rstn(rstn),
		.update(update_r && auto_mode), // [R1] [R2] [R3] [R12]
		.freeze(cs == 5'd0 && freewheel_en),
		.gain(reg_gain),
		.target({cs, 3'b000}),
		.measured(sample_r),
		.corr_r(corr)
	);

	step_amp_divider u_div (
		.core_clk(core_clk),
		.rstn(rstn),
		.start(period_start),
		.gradient(grad_use),
		.step_interval(step_interval_r),
		.quot_r(vel_quot)
	);

	// Tuning: offset in standstill at run current, gradient while moving.
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			tuned_offset_r <= 8'h00;
			tuned_grad_r <= 8'h00;
			ofs_done_r <= 1'b0;
			grad_done_r <= 1'b0;
			grad_steps_r <= 11'd0;
		end else if (auto_mode) begin
			if (update_r && standstill && cs == run_current_scale &&
				cs >= `CS_TUNE_MIN) begin // [R7]
				ofs_done_r <= 1'b1;
				if (corr > 10'sd0 && tuned_offset_r != 8'hff)
					tuned_offset_r <= tuned_offset_r + 8'h01;
				else if (corr < 10'sd0 && tuned_offset_r != 8'h00)
					tuned_offset_r <= tuned_offset_r - 8'h01;
			end
			// Gradient moves by one per eight full steps of motion.
			if (step_pulse && !standstill) begin
				grad_steps_r <= grad_steps_r + 11'd1;
				if (grad_steps_r == `GRAD_STEPS) begin
					grad_done_r <= 1'b1;
					if (corr > 10'sd0 && tuned_grad_r != 8'hff)
						tuned_grad_r <= tuned_grad_r + 8'h01; // [R3]
					else if (corr < 10'sd0 && tuned_grad_r != 8'h00)
						tuned_grad_r <= tuned_grad_r - 8'h01;
				end
			end
		end
	end

	assign ofs_use = auto_mode ? tuned_offset_r : amplitude_offset; // [R9] [R10]
	assign grad_use = auto_mode ? tuned_grad_r : gradient; // [R9] [R10]
	assign ofs_prod = ofs_use * ({1'b0, cs} + 6'd1);

	// Total amplitude; the correction only acts while regulation runs.
	always @* begin
		sum_s = {9'h000, ofs_prod[13:5]} + {2'b00, vel_quot}; // [R14]
		if (auto_mode)
			sum_s = sum_s + {{8{corr[9]}}, corr}; // [R1]
		if (sum_s[17])
			total_nxt = 10'd0;
		else if (sum_s[16:0] > {7'h00, `AMP_MAX})
			total_nxt = `AMP_MAX; // [R18]
		else
			total_nxt = sum_s[9:0];
		if (cs == 5'd0 && freewheel_en)
			total_nxt = 10'd0; // [R11]
	end

	assign sine_prod = pwm_amplitude * `SINE_PEAK;

	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			total_amplitude <= 10'd0;
			pwm_amplitude <= 8'h00;
			sine_peak_level <= 8'h00;
		end else begin
			total_amplitude <= total_nxt;
			pwm_amplitude <= (total_nxt > `AMP8_MAX) ? 8'hff : total_nxt[7:0]; // [R16]
			sine_peak_level <= sine_prod[15:8]; // [R16]
		end
	end
endmodule

// ===== verif/coil_model.sv
// Coil model: chopper phases and a current reading that follows the amplitude.
`timescale 1ns/1ns
module coil_model (
	input wire core_clk,
	input wire rstn,
	input wire period_start,
	input wire [7:0] pwm_amplitude,
	output reg chop_on_phase,
	output reg slow_decay_phase,
	output reg [7:0] coil_current
);
	reg [7:0] tick_r;
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			tick_r <= 8'hff;
			chop_on_phase <= 1'b0;
			slow_decay_phase <= 1'b0;
			coil_current <= 8'h00;
		end else begin
			if (period_start)
				tick_r <= 8'h00;
			else if (tick_r != 8'hff)
				tick_r <= tick_r + 8'h01;
			chop_on_phase <= tick_r < 8'h64;
			slow_decay_phase <= tick_r >= 8'h64 && tick_r < 8'hb4;
			// Outside both phases the reading is scrambled so a stray sample spoils regulation.
			coil_current <= tick_r < 8'hb4 ? pwm_amplitude : ~pwm_amplitude;
		end
	end
endmodule

// ===== verif/pwm_amp_asserts.sv
// Port checker for the voltage PWM amplitude regulator.
`timescale 1ns/1ns
module pwm_amp_checker (
	input wire core_clk,
	input wire rstn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hready,
	input wire [31:0] hrdata,
	input wire [9:0] total_amplitude,
	input wire [7:0] pwm_amplitude,
	input wire [7:0] sine_peak_level,
	input wire period_start
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	reg [9:0] gap_r;
	wire rd_req = hsel && htrans[1] && hready && !hwrite;
	wire [15:0] peak_prod = {8'h00, pwm_amplitude} * 16'h00f8;
	// The gap counter saturates so the first pulse after reset is never judged short.
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			gap_r <= 10'h3ff;
		else if (period_start)
			gap_r <= 10'h000;
		else if (gap_r != 10'h3ff)
			gap_r <= gap_r + 10'h001;
	end
	sequence total_settled;
		$stable(total_amplitude) ##1 $stable(total_amplitude);
	endsequence
	sequence rd_at(logic [31:0] a);
		rd_req && haddr == a;
	endsequence
	chk_sine_scale: assert property (sine_peak_level == $past(peak_prod[15:8]))
		else $error("sine peak level not scaled from amplitude");
	chk_amp_clamp: assert property (total_settled |-> pwm_amplitude ==
		(total_amplitude > 10'h0ff ? 8'hff : total_amplitude[7:0]))
		else $error("pwm amplitude not clamped total");
	chk_period_pulse: assert property (period_start |=> !period_start)
		else $error("period start longer than one cycle");
	chk_period_gap: assert property (period_start |-> gap_r >= 10'h0cc)
		else $error("chopper period shorter than shortest setting");
	chk_status_total: assert property (rd_at(32'h8) |=> hrdata[9:0] == $past(total_amplitude))
		else $error("status read total differs");
	chk_status_pwm: assert property (rd_at(32'h8) |=> hrdata[23:16] == $past(pwm_amplitude))
		else $error("status read amplitude differs");
	chk_tuned_rsvd: assert property (rd_at(32'hc) |=> hrdata[31:18] == 14'h0000)
		else $error("tuned value reserved bits set");
	chk_step_rsvd: assert property (rd_at(32'h10) |=> hrdata[31:20] == 12'h000)
		else $error("step interval reserved bits set");
endmodule
bind voltage_pwm_amplitude_regulator pwm_amp_checker u_chk (.core_clk(core_clk), .rstn(rstn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hrdata(hrdata), .total_amplitude(total_amplitude), .pwm_amplitude(pwm_amplitude),
	.sine_peak_level(sine_peak_level), .period_start(period_start));

// ===== verif/voltage_pwm_amplitude_regulator_tb.sv
// Self-checking bench for the voltage PWM amplitude regulator.
`timescale 1ns/1ns
`include "pwm_amp_consts.vh"
module voltage_pwm_amplitude_regulator_tb;
	reg core_clk = 1'b0;
	reg rstn = 1'b0;
	reg hsel = 1'b0;
	reg [31:0] haddr = 32'h0;
	reg [1:0] htrans = 2'h0;
	reg hwrite = 1'b0;
	reg [2:0] hsize = 3'h2;
	reg [31:0] hwdata = 32'h0;
	reg step_pulse = 1'b0;
	reg step_en = 1'b0;
	reg [5:0] sc = 6'h00;
	reg [31:0] rd;
	wire [31:0] hrdata;
	wire hreadyout;
	wire hresp;
	wire chop_on_phase;
	wire slow_decay_phase;
	wire [7:0] coil_current;
	wire [9:0] total_amplitude;
	wire [7:0] pwm_amplitude;
	wire [7:0] sine_peak_level;
	wire period_start;
	integer fails = 0;
	integer n_compared = 0;
	always #5 core_clk = ~core_clk;
	voltage_pwm_amplitude_regulator dut (.core_clk(core_clk), .rstn(rstn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.step_pulse(step_pulse), .chop_on_phase(chop_on_phase),
		.slow_decay_phase(slow_decay_phase), .coil_current(coil_current),
		.total_amplitude(total_amplitude), .pwm_amplitude(pwm_amplitude),
		.sine_peak_level(sine_peak_level), .period_start(period_start));
	coil_model partner (.core_clk(core_clk), .rstn(rstn), .period_start(period_start),
		.pwm_amplitude(pwm_amplitude), .chop_on_phase(chop_on_phase),
		.slow_decay_phase(slow_decay_phase), .coil_current(coil_current));
	always @(posedge core_clk) begin
		sc <= sc == 6'h31 ? 6'h00 : sc + 6'h01;
		step_pulse <= step_en && sc == 6'h31;
	end
	task conclude;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task cmp(input [31:0] got, input [31:0] exp);
		n_compared = n_compared + 1;
		if (got !== exp) begin
			fails = fails + 1;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task ahb(input w, input [31:0] a, input [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task wr(input [31:0] a, input [31:0] d);
		ahb(1'b1, a, d);
	endtask
	task rdc(input [31:0] a, input [31:0] exp);
		ahb(1'b0, a, 32'h0);
		cmp(rd, exp);
		cmp({31'h0, hresp}, 32'h0);
	endtask
	task do_reset;
		rstn <= 1'b0;
		repeat (3) @(posedge core_clk);
		rstn <= 1'b1;
		@(posedge core_clk);
	endtask
	task wait_periods(input integer n);
		repeat (n) begin
			@(negedge core_clk);
			while (period_start !== 1'b1) @(negedge core_clk);
		end
	endtask
	task t_regs;
		do_reset;
		rdc(32'h0, `CHOP_CFG_RESET);
		rdc(32'h4, `CUR_CFG_RESET);
		rdc(32'h10, 32'h000fffff);
		wr(32'h14, 32'hffffffff);
		rdc(32'h14, 32'h0);
		wr(32'h8, 32'hffffffff);
		rdc(32'h8, 32'h0);
		wr(32'hc, 32'hffffffff);
		rdc(32'hc, 32'h0);
		wr(32'h0, 32'hffffffff);
		rdc(32'h0, 32'h0f7fffff);
		wr(32'h4, 32'hffffffff);
		rdc(32'h4, 32'h00ff1f1f);
	endtask
	task t_periods;
		integer f;
		integer n;
		reg [9:0] per;
		for (f = 0; f < 4; f = f + 1) begin
			per = f == 0 ? `PERIOD_F0 : f == 1 ? `PERIOD_F1 : f == 2 ? `PERIOD_F2 : `PERIOD_F3;
			do_reset;
			wr(32'h0, f << 16);
			wait_periods(1);
			n = 0;
			do begin
				@(negedge core_clk);
				n = n + 1;
			end while (period_start !== 1'b1);
			cmp(n, {22'h0, per});
		end
	endtask
	// Velocity mode with autoscale off; expected total and clamped amplitude from status.
	task vel_case(input [31:0] cur, input [7:0] ofs, input [7:0] grad, input [9:0] exp);
		do_reset;
		wr(32'h4, cur);
		wr(32'h0, {16'h0003, grad, ofs});
		wait_periods(3);
		rdc(32'h8, {8'h00, exp > 10'h0ff ? 8'hff : exp[7:0], 6'h00, exp});
	endtask
	task t_auto(input [31:0] cfg);
		do_reset;
		wr(32'h4, 32'h00000f00);
		wr(32'h0, cfg);
		wait_periods(70);
		@(negedge core_clk);
		// Target is run scale 15 times 8 on the coil reading scale.
		cmp({31'h0, pwm_amplitude >= 8'h70 && pwm_amplitude <= 8'h80}, 32'h1);
		// Standstill at run current tunes the offset; without motion the gradient stays untuned.
		ahb(1'b0, 32'hc, 32'h0);
		cmp({16'h0000, rd[31:16]}, 32'h00000001);
	endtask
	initial begin
		#800000;
		fails = fails + 1;
		conclude;
	end
	initial begin
		t_regs;
		t_periods;
		vel_case(32'h00001f00, 8'h40, 8'h00, 10'h040);
		vel_case(32'h00801f07, 8'h80, 8'h00, 10'h020);
		vel_case(32'h00801f00, 8'h80, 8'h00, 10'h004);
		vel_case(32'h00c01f00, 8'h80, 8'h00, 10'h000);
		vel_case(32'h00231f00, 8'h80, 8'h00, 10'h010);
		step_en <= 1'b1;
		vel_case(32'h00001f00, 8'hff, 8'hff, `AMP_MAX);
		@(negedge core_clk);
		cmp({24'h0, sine_peak_level}, (32'h000000ff * `SINE_PEAK) >> 8);
		step_en <= 1'b0;
		t_auto(32'h084f0000);
		t_auto(32'h080f0000);
		conclude;
	end
endmodule
